//--- tdm_mc_ctrl.sv
// multichannel pair control: register slave, frame sequencer, slot transmit and receive
`timescale 1ns/1ps
// Operation
// R01: two partner ports share this one control register and frame engine
// R02: bit 0 enables multichannel operation only while operating mode select is 0
// R03: delay field bits 4..1 inserts 1 to 15 serial clocks before first bit
// R04: delay zero makes frame sync coincide with the first data bit
// R05: bits 11..5 hold slots per frame minus one, 1 to 128 slots
// R06: bit 12 loops the pair's transmitter into its partner receiver
// R07: each port's direction bit picks transmitter or receiver in loopback
// R08: bits 22..16 read the current transmit slot, held until next slot
// R09: bit 23 enables the B port of the pair
// R10: bits 27..24 read DMA active status of both ports, channels A and B
// R11: bits 31..28 read chain descriptor load status, channels A and B
// R12: four 32-bit transmit select words mark slots 0 to 127 active
// R13: an active transmit slot sends its word in that slot position
// R14: an unselected transmit slot leaves the data output undriven all slot
// R15: a transmit compand bit applies the chosen law to the outgoing word
// R16: a clear transmit compand bit sends the word unchanged
// R17: a selected receive slot loads its word into the receive buffer
// R18: an unselected receive slot is ignored and loads nothing
// R19: a receive compand bit expands the received word by the chosen law
// R20: a clear receive compand bit passes the received word unchanged
// R21: slot n maps to bit n mod 32 of map word n div 32
// R22: reserved control bits 15..13 read zero and ignore writes
module tdm_mc_ctrl (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [tdm_pkg::ADDR_W-1:0] awaddr_in,
	input wire logic wvalid_in,
	output logic wready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	output logic bvalid_out,
	input wire logic bready_in,
	output logic [1:0] bresp_out,
	input wire logic arvalid_in,
	output logic arready_out,
	input wire logic [tdm_pkg::ADDR_W-1:0] araddr_in,
	output logic rvalid_out,
	input wire logic rready_in,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	input wire logic [3:0] dma_active_in,
	input wire logic [3:0] chain_load_in,
	input wire tdm_pkg::tdm_link_in_t link_in,
	output tdm_pkg::tdm_link_out_t link_out
);
	import tdm_pkg::*;

	logic [31:0] ctrl_q;
	logic [31:0] mode_q;
	logic [15:0] tx_hold;
	logic [3:0][31:0] tx_sel;
	logic [3:0][31:0] tx_cmp;
	logic [3:0][31:0] rx_sel;
	logic [3:0][31:0] rx_cmp;
	logic [15:0] rx_buf;
	logic rx_valid;
	logic [6:0] cur_slot;
	logic aw_full;
	logic w_full;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic sclk_d;
	tdm_state_t state;
	tdm_state_t next_state;
	logic [6:0] slot;
	logic [2:0] bit_cnt;
	logic [3:0] dly_cnt;
	logic [7:0] tx_shift;
	logic [7:0] rx_shift;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (val & m);
	endfunction : merge

	// register bus decode
	wire aw_hs = awvalid_in & awready_out;
	wire w_hs = wvalid_in & wready_out;
	wire do_write = aw_full & w_full & ~bvalid_out;
	wire wr_hit = aw_addr[7:2] <= OFF_LAST[7:2];
	wire [4:0] wr_idx = aw_addr[6:2];
	wire [2:0] wr_grp = wr_idx[4:2];
	wire [1:0] wr_word = wr_idx[1:0];
	wire ar_hs = arvalid_in & arready_out;
	wire rd_hit = araddr_in[7:2] <= OFF_LAST[7:2];
	wire [4:0] rd_idx = araddr_in[6:2];
	wire [2:0] rd_grp = rd_idx[4:2];
	wire [1:0] rd_word = rd_idx[1:0];
	wire rx_rd = ar_hs & rd_hit & (rd_idx == OFF_RXDATA[6:2]);

	assign awready_out = ~aw_full & ~bvalid_out;
	assign wready_out = ~w_full & ~bvalid_out;
	assign arready_out = ~rvalid_out;

	// status fields come from cur_slot and the live inputs, not ctrl_q, so writes cannot disturb them
	wire [31:0] ctrl_rd = (ctrl_q & CTL_WMASK) // R22
		| ({25'h0, cur_slot} << CTL_SLOT_LO) // R08
		| ({28'h0, dma_active_in} << CTL_DMA_LO) // R10
		| ({28'h0, chain_load_in} << CTL_CHN_LO); // R11
	wire [31:0] rx_rd_word = {15'h0, rx_valid, rx_buf};
	wire [31:0] map_rd = (rd_grp == OFF_TX_SEL[6:4]) ? tx_sel[rd_word] :
		(rd_grp == OFF_TX_CMP[6:4]) ? tx_cmp[rd_word] :
		(rd_grp == OFF_RX_SEL[6:4]) ? rx_sel[rd_word] : rx_cmp[rd_word];
	wire [31:0] rd_mux = (rd_idx == OFF_CTRL[6:2]) ? ctrl_rd :
		(rd_idx == OFF_MODE[6:2]) ? mode_q :
		(rd_idx == OFF_TXDATA[6:2]) ? {16'h0, tx_hold} :
		(rd_idx == OFF_RXDATA[6:2]) ? rx_rd_word : map_rd;

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			bvalid_out <= 1'b0;
			bresp_out <= RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_full <= 1'b1;
				aw_addr <= awaddr_in;
			end
			if (w_hs) begin
				w_full <= 1'b1;
				w_data <= wdata_in;
				w_strb <= wstrb_in;
			end
			if (do_write) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				bvalid_out <= 1'b1;
				bresp_out <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bready_in) begin
				bvalid_out <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			rvalid_out <= 1'b0;
			rdata_out <= 32'h0;
			rresp_out <= RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_out <= 1'b1;
			rdata_out <= rd_hit ? rd_mux : 32'h0;
			rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready_in) begin
			rvalid_out <= 1'b0;
		end
	end

	// software-written registers
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			ctrl_q <= CTRL_RST;
			mode_q <= MODE_RST;
			tx_hold <= TXDATA_RST;
			tx_sel <= {4{MAP_RST}};
			tx_cmp <= {4{MAP_RST}};
			rx_sel <= {4{MAP_RST}};
			rx_cmp <= {4{MAP_RST}};
		end else if (do_write && wr_hit) begin
			if (wr_idx == OFF_CTRL[6:2]) ctrl_q <= merge(ctrl_q, w_data, w_strb) & CTL_WMASK; // R22
			if (wr_idx == OFF_MODE[6:2]) mode_q <= merge(mode_q, w_data, w_strb) & MODE_WMASK;
			if (wr_idx == OFF_TXDATA[6:2]) tx_hold <= 16'(merge({16'h0, tx_hold}, w_data, w_strb));
			if (wr_grp == OFF_TX_SEL[6:4]) tx_sel[wr_word] <= merge(tx_sel[wr_word], w_data, w_strb);
			if (wr_grp == OFF_TX_CMP[6:4]) tx_cmp[wr_word] <= merge(tx_cmp[wr_word], w_data, w_strb);
			if (wr_grp == OFF_RX_SEL[6:4]) rx_sel[wr_word] <= merge(rx_sel[wr_word], w_data, w_strb);
			if (wr_grp == OFF_RX_CMP[6:4]) rx_cmp[wr_word] <= merge(rx_cmp[wr_word], w_data, w_strb);
		end
	end

	// link pins pass two flops; a third copy of the clock finds its falling edge
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			sclk_d <= 1'b0;
		end else begin
			sync1 <= link_in;
			sync2 <= sync1;
			sclk_d <= sync2[3];
		end
	end

	wire sclk_s = sync2[3];
	wire fs_s = sync2[2];
	wire da_s = sync2[1];
	wire db_s = sync2[0];
	wire fall = ~sclk_s & sclk_d;

	wire mc_on = ctrl_q[CTL_EN_A] & ~mode_q[MODE_OPM]; // R02
	wire en_b = ctrl_q[CTL_EN_B]; // R09
	wire [3:0] dly = ctrl_q[CTL_DLY_LO +: 4];
	wire [6:0] slot_cnt = ctrl_q[CTL_CNT_LO +: 7];
	wire loop_on = ctrl_q[CTL_LOOP];
	wire dir_a = mode_q[MODE_DIR_A];
	wire dir_b = mode_q[MODE_DIR_B];
	wire [1:0] dt = mode_q[MODE_DT_LO +: 2];
	wire law_on = dt[1];
	wire [127:0] tx_sel_flat = tx_sel; // R12 R21
	wire [127:0] tx_cmp_flat = tx_cmp; // R21
	wire [127:0] rx_sel_flat = rx_sel; // R21
	wire [127:0] rx_cmp_flat = rx_cmp; // R21

	wire start0 = mc_on & fall & fs_s & (state == ST_IDLE);
	wire bit_fall = mc_on & fall & ((state == ST_SLOT) | (start0 & (dly == 4'h0)) // R04
		| ((state == ST_DELAY) & (dly_cnt == 4'h1))); // R03
	wire slot_end = bit_fall & (bit_cnt == BIT_LAST);
	wire frame_end = slot_end & (slot == slot_cnt); // R05
	wire [6:0] next_slot = slot + 7'h01;
	wire [6:0] ws = slot_end ? next_slot : slot;

	wire [7:0] code_c;
	wire [15:0] lin_e;
	wire [7:0] tx_word = (tx_cmp_flat[ws] & law_on) ? code_c : tx_hold[7:0]; // R15 R16
	wire tx_bit = tx_shift[7];
	// with loopback the partner never leaves the chip; pins still carry the stream
	wire rx_src = ~dir_a ? da_s : db_s; // R07
	wire din = loop_on ? tx_bit : rx_src; // R06
	wire rx_active = ~dir_a | (~dir_b & en_b); // R01
	wire [7:0] rx_word = {rx_shift[6:0], din};
	wire rx_take = slot_end & rx_sel_flat[slot] & rx_active; // R17 R18
	wire [15:0] rx_value = (rx_cmp_flat[slot] & law_on) ? lin_e : {8'h00, rx_word}; // R19 R20
	wire tx_drive = mc_on & tx_sel_flat[slot]; // R13 R14

	tdm_compand u_compand (
		.law_in(dt),
		.lin_in(tx_hold),
		.code_in(rx_word),
		.code_out(code_c),
		.lin_out(lin_e)
	);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start0) next_state = (dly == 4'h0) ? ST_SLOT : ST_DELAY;
			end
			ST_DELAY: begin
				if (bit_fall) next_state = ST_SLOT;
			end
			ST_SLOT: begin
				if (frame_end) next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		if (!mc_on) next_state = ST_IDLE;
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			state <= ST_IDLE;
			slot <= 7'h00;
			bit_cnt <= 3'h0;
			dly_cnt <= 4'h0;
			tx_shift <= 8'h00;
			rx_shift <= 8'h00;
		end else begin
			state <= next_state;
			if (start0) dly_cnt <= dly;
			else if (fall && state == ST_DELAY) dly_cnt <= dly_cnt - 4'h1;
			if (bit_fall) begin
				bit_cnt <= bit_cnt + 3'h1;
				rx_shift <= rx_word;
				tx_shift <= slot_end ? tx_word : {tx_shift[6:0], 1'b0}; // R13
				if (slot_end) slot <= frame_end ? 7'h00 : next_slot; // R05
			end else if (state == ST_IDLE) begin
				// slot 0 is preloaded so a zero delay can send on the sync edge
				tx_shift <= tx_word;
				bit_cnt <= 3'h0;
				slot <= 7'h00;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			cur_slot <= 7'h00;
			rx_buf <= 16'h0000;
			rx_valid <= 1'b0;
			link_out <= '0;
		end else begin
			if (bit_fall && bit_cnt == 3'h0) cur_slot <= slot; // R08
			if (rx_take) rx_buf <= rx_value; // R17
			rx_valid <= rx_take | (rx_valid & ~rx_rd);
			link_out.data_a <= tx_bit;
			link_out.data_b <= tx_bit;
			link_out.oe_a <= tx_drive & dir_a; // R14
			link_out.oe_b <= tx_drive & dir_b & en_b; // R09 R14
		end
	end

	property p_reserved_zero;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(ar_hs && rd_idx == OFF_CTRL[6:2]) |=> rdata_out[15:13] == 3'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // R22

	property p_mc_off;
		@(posedge core_clk_in) disable iff (!nrst_in)
		!mc_on |=> state == ST_IDLE && !link_out.oe_a && !link_out.oe_b;
	endproperty
	a_mc_off: assert property (p_mc_off) else $error("engine active while disabled"); // R02

	property p_delay_zero;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(start0 && dly == 4'h0) |=> state == ST_SLOT && bit_cnt == 3'h1;
	endproperty
	a_delay_zero: assert property (p_delay_zero) else $error("zero delay not immediate"); // R04

	property p_delay_load;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(start0 && dly != 4'h0) |=> state == ST_DELAY && dly_cnt == $past(dly) && bit_cnt == 3'h0;
	endproperty
	a_delay_load: assert property (p_delay_load) else $error("frame delay wrong"); // R03

	property p_slot_wrap;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(slot_end && slot == slot_cnt && mc_on) |=> state == ST_IDLE && slot == 7'h00;
	endproperty
	a_slot_wrap: assert property (p_slot_wrap) else $error("frame did not end"); // R05

	property p_tx_tristate;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(state == ST_SLOT && !tx_sel_flat[slot]) |=> !link_out.oe_a && !link_out.oe_b;
	endproperty
	a_tx_tristate: assert property (p_tx_tristate) else $error("unselected slot driven"); // R14

	property p_rx_load;
		@(posedge core_clk_in) disable iff (!nrst_in)
		rx_take |=> rx_valid && rx_buf == $past(rx_value);
	endproperty
	a_rx_load: assert property (p_rx_load) else $error("selected slot not loaded"); // R17

	property p_rx_ignore;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(slot_end && !rx_sel_flat[slot]) |=> $stable(rx_buf);
	endproperty
	a_rx_ignore: assert property (p_rx_ignore) else $error("ignored slot loaded"); // R18

	property p_cur_slot;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(bit_fall && bit_cnt == 3'h0) |=> cur_slot == $past(slot) && ctrl_rd[22:16] == $past(slot);
	endproperty
	a_cur_slot: assert property (p_cur_slot) else $error("current slot not reported"); // R08

	property p_loop_rx;
		@(posedge core_clk_in) disable iff (!nrst_in)
		(bit_fall && loop_on) |=> rx_shift[0] == $past(tx_bit);
	endproperty
	a_loop_rx: assert property (p_loop_rx) else $error("loopback bit mismatch"); // R06

	c_frame_end: cover property (@(posedge core_clk_in) disable iff (!nrst_in) frame_end);
	c_delay_frame: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
		state == ST_DELAY ##1 state == ST_SLOT);
	c_loop_take: cover property (@(posedge core_clk_in) disable iff (!nrst_in) rx_take && loop_on);
endmodule : tdm_mc_ctrl

//--- tdm_pkg.sv
// shared constants and types for the multichannel pair control block
package tdm_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MODE = 8'h04;
	localparam logic [7:0] OFF_TXDATA = 8'h08;
	localparam logic [7:0] OFF_RXDATA = 8'h0c;
	localparam logic [7:0] OFF_TX_SEL = 8'h10;
	localparam logic [7:0] OFF_TX_CMP = 8'h20;
	localparam logic [7:0] OFF_RX_SEL = 8'h30;
	localparam logic [7:0] OFF_RX_CMP = 8'h40;
	localparam logic [7:0] OFF_LAST = 8'h4c;
	localparam int CTL_EN_A = 0;
	localparam int CTL_DLY_LO = 1;
	localparam int CTL_CNT_LO = 5;
	localparam int CTL_LOOP = 12;
	localparam int CTL_RSV_LO = 13;
	localparam int CTL_SLOT_LO = 16;
	localparam int CTL_EN_B = 23;
	localparam int CTL_DMA_LO = 24;
	localparam int CTL_CHN_LO = 28;
	localparam logic [31:0] CTL_WMASK = 32'h00801fff;
	localparam int MODE_OPM = 0;
	localparam int MODE_DIR_A = 1;
	localparam int MODE_DIR_B = 2;
	localparam int MODE_DT_LO = 4;
	localparam logic [31:0] MODE_WMASK = 32'h00000037;
	localparam int RX_VALID_BIT = 16;
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [31:0] MODE_RST = 32'h00000000;
	localparam logic [31:0] MAP_RST = 32'h00000000;
	localparam logic [15:0] TXDATA_RST = 16'h0000;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] LAW_MU = 2'h2;
	localparam logic [1:0] LAW_A = 2'h3;
	localparam logic [15:0] MU_BIAS = 16'h0084;
	localparam logic [7:0] A_LAW_XOR = 8'h55;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DELAY = 3'b010,
		ST_SLOT = 3'b100
	} tdm_state_t;
	typedef struct packed {
		logic sclk;
		logic fsync;
		logic data_a;
		logic data_b;
	} tdm_link_in_t;
	typedef struct packed {
		logic data_a;
		logic oe_a;
		logic data_b;
		logic oe_b;
	} tdm_link_out_t;
endpackage : tdm_pkg

//--- tdm_compand.sv
// segment compander: linear word to 8-bit law code and back
`timescale 1ns/1ps
module tdm_compand (
	input wire logic [1:0] law_in,
	input wire logic [15:0] lin_in,
	input wire logic [7:0] code_in,
	output logic [7:0] code_out,
	output logic [15:0] lin_out
);
	import tdm_pkg::*;

	logic [15:0] bias;
	logic [15:0] mag;
	logic [15:0] biased;
	logic [2:0] seg;
	logic [15:0] shifted;
	logic [7:0] raw_c;
	logic [7:0] raw_e;
	logic [15:0] e_base;
	logic [15:0] e_mag;

	assign bias = (law_in == LAW_MU) ? MU_BIAS : 16'h0000;
	assign mag = lin_in[15] ? (16'h0000 - lin_in) : lin_in;
	// saturate so the most negative input cannot wrap into a small code
	assign biased = (mag > (16'h7fff - bias)) ? 16'h7fff : (mag + bias);

	always_comb begin
		seg = 3'h0;
		for (int i = 0; i < 7; i++) begin
			if (biased[i + 8]) begin
				seg = 3'(i + 1);
			end
		end
	end

	assign shifted = biased >> ({1'b0, seg} + 4'h3);
	assign raw_c = {lin_in[15], seg, shifted[3:0]};
	assign code_out = (law_in == LAW_MU) ? ~raw_c : (raw_c ^ A_LAW_XOR);

	assign raw_e = (law_in == LAW_MU) ? ~code_in : (code_in ^ A_LAW_XOR);
	assign e_base = {8'h01, raw_e[3:0], 4'h4} >> 1;
	assign e_mag = (e_base << raw_e[6:4]) - bias;
	assign lin_out = raw_e[7] ? (16'h0000 - e_mag) : e_mag;
endmodule : tdm_compand

//--- tdm_far_model.sv
// far-side codec model: serial clock, frame sync and receive data out, transmit slots captured
`timescale 1ns/1ps
module tdm_far_model (
	output tdm_pkg::tdm_link_in_t pins_out,
	input wire tdm_pkg::tdm_link_out_t pins_in
);
	import tdm_pkg::*;
	localparam int HALF = 400;
	logic [7:0] got [0:128];
	logic [7:0] got_b [0:128];
	logic oe_any [0:128];
	logic oe_b_any [0:128];
	logic oe_all [0:128];
	initial begin
		pins_out = '{sclk: 1'b1, fsync: 1'b0, data_a: 1'b0, data_b: 1'b1};
	end
	// one frame: the clock runs only for the frame plus nine trailing falls
	task automatic run_frame(input int dly, input int nsl);
		int b;
		int s;
		logic [7:0] w;
		for (int i = 0; i <= nsl; i++) begin
			got[i] = 8'h00;
			got_b[i] = 8'h00;
			oe_any[i] = 1'b0;
			oe_b_any[i] = 1'b0;
			oe_all[i] = 1'b1;
		end
		for (int f = 0; f < dly + 8 * nsl + 9; f++) begin
			b = f - dly;
			s = (b < 0) ? 0 : b / 8;
			w = 8'h60 + s[7:0];
			pins_out.fsync = (f == 0);
			// no defined level outside the slots, so the line toggles instead of holding
			pins_out.data_b = (b >= 0 && s < nsl) ? w[7 - b % 8] : ~pins_out.data_b;
			pins_out.data_a = ~pins_out.data_a;
			#HALF pins_out.sclk = 1'b0;
			if (b >= 0 && s <= nsl) begin
				got[s][7 - b % 8] = pins_in.data_a;
				got_b[s][7 - b % 8] = pins_in.data_b;
				oe_any[s] = oe_any[s] | pins_in.oe_a;
				oe_b_any[s] = oe_b_any[s] | pins_in.oe_b;
				oe_all[s] = oe_all[s] & pins_in.oe_a;
			end
			#HALF pins_out.sclk = 1'b1;
		end
		pins_out.fsync = 1'b0;
	endtask : run_frame
endmodule : tdm_far_model

//--- tdm_mc_ctrl_tb.sv
// self-checking bench: registers over AXI4-Lite and TDM frames against the far-side model
`timescale 1ns/1ps
module tdm_mc_ctrl_tb;
	import tdm_pkg::*;
	logic core_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0, dma = 4'h0, chain = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	tdm_link_in_t link_in;
	tdm_link_out_t link_out;
	int fails = 0;
	int tests_run = 0;
	initial begin
		forever #50 core_clk_in = ~core_clk_in;
	end
	tdm_mc_ctrl tdm_mc_ctrl_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
		.awvalid_in(awvalid), .awready_out(awready), .awaddr_in(awaddr),
		.wvalid_in(wvalid), .wready_out(wready), .wdata_in(wdata), .wstrb_in(wstrb),
		.bvalid_out(bvalid), .bready_in(bready), .bresp_out(bresp),
		.arvalid_in(arvalid), .arready_out(arready), .araddr_in(araddr),
		.rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata), .rresp_out(rresp),
		.dma_active_in(dma), .chain_load_in(chain), .link_in(link_in), .link_out(link_out));
	tdm_far_model tdm_far_model_i (.pins_out(link_in), .pins_in(link_out));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask : chk
	task automatic hang;
		$display("BAD bus answer expected within 50 cycles seen none");
		fails++;
		end_sim();
	endtask : hang
	// ready is looked at mid-cycle, where it has settled, and acted on at the next edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, tb;
		@(posedge core_clk_in);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hf;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge core_clk_in);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			if (tb) resp = bresp;
			@(posedge core_clk_in);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) break;
		end
		bready <= 1'b0;
		if (n == 50) hang();
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		int n;
		logic ta, tr;
		@(posedge core_clk_in);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge core_clk_in);
			ta = arvalid & arready;
			tr = rvalid;
			if (tr) rd = rdata;
			if (tr) resp = rresp;
			@(posedge core_clk_in);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		rready <= 1'b0;
		if (n == 50) hang();
	endtask : rdr
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		rdr(a);
		chk(nm, exp, rd);
	endtask : rchk
	function automatic logic [31:0] ctl(input int dly, input int slot_count_minus_one, input logic lp, input logic eb);
		return {8'h00, eb, 7'h00, 3'h0, lp, slot_count_minus_one[6:0], dly[3:0], 1'b1};
	endfunction : ctl
	// the read first clears any stale receive flag
	task automatic frame(input logic [31:0] c, input int dly, input int nsl);
		rdr(OFF_RXDATA);
		wr(OFF_CTRL, c);
		tdm_far_model_i.run_frame(dly, nsl);
	endtask : frame
	initial begin
		#3000000;
		$display("BAD run length expected under 30000 cycles seen more");
		fails++;
		end_sim();
	end
	initial begin
		int dl[2];
		logic [31:0] bad[3];
		dl = '{1, 15};
		bad = '{ctl(0, 0, 0, 1), ctl(0, 0, 0, 0), ctl(0, 0, 0, 1) & 32'hfffffffe};
		repeat (12) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		for (int a = 0; a <= 'h4c; a += 4) rchk("reset value", a[7:0], 32'h0);
		rdr(8'h50);
		chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		chk("unmapped read data", 32'h0, rd);
		wr(8'h50, 32'hffffffff);
		chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
		dma <= 4'ha;
		chain <= 4'h5;
		wr(OFF_CTRL, 32'hffffffff);
		rchk("control", OFF_CTRL, 32'h5a801fff);
		dma <= 4'h3;
		chain <= 4'hc;
		rchk("control", OFF_CTRL, 32'hc3801fff);
		wr(OFF_CTRL, 32'h0);
		for (int i = 0; i < 16; i++) wr(8'(OFF_TX_SEL + 4 * i), {i[7:0], 24'h5a0f3c});
		for (int i = 0; i < 16; i++) rchk("map word", 8'(OFF_TX_SEL + 4 * i), {i[7:0], 24'h5a0f3c});
		for (int i = 0; i < 16; i++) wr(8'(OFF_TX_SEL + 4 * i), 32'h0);
		wr(OFF_MODE, 32'h2);
		wr(OFF_TXDATA, 32'ha5);
		wr(8'h14, 32'h2);
		wr(8'h34, 32'h4);
		frame(ctl(0, 34, 0, 1), 0, 35);
		chk("slot 33 word", 32'ha5, 32'(tdm_far_model_i.got[33]));
		chk("slot 33 driven", 32'h1, 32'(tdm_far_model_i.oe_all[33]));
		for (int s = 0; s <= 35; s++) begin
			if (s != 33) chk("idle slot", 32'h0, 32'(tdm_far_model_i.oe_any[s]));
		end
		rchk("rx slot 34", OFF_RXDATA, 32'h00010082);
		rchk("rx after read", OFF_RXDATA, 32'h00000082);
		rdr(OFF_CTRL);
		chk("current slot", 32'd34, 32'(rd[22:16]));
		wr(8'h14, 32'h0);
		wr(8'h34, 32'h0);
		wr(OFF_TX_SEL, 32'h4);
		wr(OFF_RX_SEL, 32'h1);
		foreach (dl[k]) begin
			frame(ctl(dl[k], 2, 0, 1), dl[k], 3);
			chk("delayed slot 2", 32'ha5, 32'(tdm_far_model_i.got[2]));
			chk("slot 1 idle", 32'h0, 32'(tdm_far_model_i.oe_any[1]));
			chk("after frame", 32'h0, 32'(tdm_far_model_i.oe_any[3]));
			rchk("delayed rx", OFF_RXDATA, 32'h00010060);
		end
		wr(OFF_TXDATA, 32'h1234);
		wr(OFF_TX_SEL, 32'h3);
		wr(OFF_TX_CMP, 32'h2);
		wr(OFF_RX_SEL, 32'h2);
		wr(OFF_RX_CMP, 32'h2);
		for (int law = 2; law <= 3; law++) begin
			wr(OFF_MODE, 32'h2 | (law << 4));
			frame(ctl(0, 1, 0, 1), 0, 2);
			chk("plain slot", 32'h34, 32'(tdm_far_model_i.got[0]));
			chk("compressed slot", 32'h1, 32'(tdm_far_model_i.got[1] !== 8'h34));
			rdr(OFF_RXDATA);
			chk("expanded rx", 32'h3, {30'h0, rd[16], rd[15:0] !== 16'h0061});
		end
		wr(OFF_TX_CMP, 32'h0);
		wr(OFF_RX_CMP, 32'h0);
		wr(OFF_TX_SEL, 32'h1);
		wr(OFF_RX_SEL, 32'h1);
		wr(OFF_TXDATA, 32'h3c);
		for (int m = 2; m <= 4; m += 2) begin
			wr(OFF_MODE, m);
			frame(ctl(0, 0, 1, 1), 0, 1);
			rchk("loopback rx", OFF_RXDATA, 32'h0001003c);
			chk("a port drive", 32'(m == 2), 32'(tdm_far_model_i.oe_any[0]));
			chk("b port drive", 32'(m == 4), 32'(tdm_far_model_i.oe_b_any[0]));
			if (m == 4) chk("b port word", 32'h3c, 32'(tdm_far_model_i.got_b[0]));
		end
		for (int k = 0; k < 3; k++) begin
			wr(OFF_MODE, (k == 0) ? 32'h3 : (k == 1) ? 32'h6 : 32'h2);
			frame(bad[k], 0, 1);
			rdr(OFF_RXDATA);
			chk("no capture", 32'h0, 32'(rd[16]));
			if (k != 1) chk("no drive", 32'h0, 32'(tdm_far_model_i.oe_any[0]));
			chk("b held off", 32'h0, 32'(tdm_far_model_i.oe_b_any[0]));
		end
		end_sim();
	end
endmodule : tdm_mc_ctrl_tb
